// >>> hdl/agu_pkg.sv
// Package with widths, opcodes and constants of the address generation unit.
// Notes on behaviour
// - Every ROM word is ten bits wide, and the table logic uses that whole width.
// - Pointer-indirect data mode forms a 10-bit RAM address from the three pointer registers.
// - A direct data access takes two words, opcode first and the 10-bit RAM address second.
// - The memory-register window is 16 digits at RAM 040h to 04Fh, used by load and exchange.
// - Long jump, long branch and call load all 14 program counter bits from the immediate.
// - Program memory is 64 pages of 256 words, upper bits page and low eight bits word.
// - The page branch replaces the low eight program counter bits and takes the page bits of the incremented PC.
// - A page branch on the last word of a page lands in the next page.
// - The zero-page call loads six low bits and clears bits 13 to 6.
// - The table branch target comes from the four-bit immediate, accumulator and B.
// - With bit 8 of the table word set, its data byte goes to accumulator and B.
// - With bit 9 of the table word set, its data byte goes to the port output registers.
// - With both bits set, accumulator pair and port registers update together.
// - The table reference leaves the program counter sequential.
package agu_pkg;
    localparam int WORD_W     = 10;
    localparam int PC_W       = 14;
    localparam int RAM_AW     = 10;
    localparam int NIB_W      = 4;
    localparam int PAGE_LSB   = 8;
    localparam int ZP_W       = 6;
    localparam int SEL_ACC_BIT  = 8;
    localparam int SEL_PORT_BIT = 9;
    localparam logic [RAM_AW-1:0] MEMREG_BASE = 10'h040;
    localparam logic [PC_W-1:0]   PC_RESET    = 14'h0000;
    localparam logic [NIB_W-1:0]  NIB_ZERO    = 4'h0;

    // Operation selected by the instruction decoder.
    typedef enum logic [3:0] {
        OP_NONE      = 4'h0,
        OP_LONG      = 4'h1,
        OP_PAGE_BR   = 4'h2,
        OP_ZERO_CALL = 4'h3,
        OP_TBL_BR    = 4'h4,
        OP_TBL_REF   = 4'h5
    } branch_op_t;

    typedef enum logic [2:0] {
        DM_INDIRECT = 3'h1,
        DM_DIRECT   = 3'h2,
        DM_MEMREG   = 3'h4
    } data_mode_t;

    // Table reference sequencing.
    typedef enum logic [1:0] {
        ST_RUN   = 2'h1,
        ST_FETCH = 2'h2
    } tbl_state_t;
endpackage

// >>> hdl/ram_addr_mux.sv
// Data RAM address selection for the three data addressing modes.
`timescale 1ns/1ps
module ram_addr_mux import agu_pkg::*; (
    // Mode and sources
    input  wire data_mode_t          mode,
    input  wire logic [NIB_W-1:0]    ptr_w,
    input  wire logic [NIB_W-1:0]    ptr_x,
    input  wire logic [NIB_W-1:0]    ptr_y,
    input  wire logic [WORD_W-1:0]   second_word,
    input  wire logic [NIB_W-1:0]    memreg_idx,
    // Result
    output logic      [RAM_AW-1:0]   ram_addr
);
    logic [RAM_AW-1:0] ind_addr;
    logic [RAM_AW-1:0] mr_addr;
    // pointer concatenation. W supplies only its two low bits.
    assign ind_addr = {ptr_w[1:0], ptr_x, ptr_y};
    assign mr_addr = MEMREG_BASE | {6'h00, memreg_idx};
    always_comb begin
        case (mode)
            DM_INDIRECT: ram_addr = ind_addr;
            DM_DIRECT:   ram_addr = second_word;
            DM_MEMREG:   ram_addr = mr_addr;
            default:     ram_addr = ind_addr;
        endcase
    end
endmodule // ram_addr_mux

// >>> hdl/address_generation_unit.sv
// Program counter, branch targets, table reference and RAM address logic.
`timescale 1ns/1ps
module address_generation_unit import agu_pkg::*; (
    // Clock and reset
    input  wire logic                ref_clk,
    input  wire logic                srst,
    // Instruction step
    input  wire logic                step,
    input  wire branch_op_t          branch_op,
    input  wire logic [PC_W-1:0]     imm_long,
    input  wire logic [NIB_W-1:0]    imm_nib,
    // Registers of the core
    input  wire logic [NIB_W-1:0]    acc_in,
    input  wire logic [NIB_W-1:0]    b_in,
    // Program ROM
    output logic      [PC_W-1:0]     rom_addr,
    input  wire logic [WORD_W-1:0]   rom_data,
    // Data RAM addressing
    input  wire data_mode_t          data_mode,
    input  wire logic [NIB_W-1:0]    ptr_w,
    input  wire logic [NIB_W-1:0]    ptr_x,
    input  wire logic [NIB_W-1:0]    ptr_y,
    input  wire logic [WORD_W-1:0]   second_word,
    input  wire logic [NIB_W-1:0]    memreg_idx,
    output logic      [RAM_AW-1:0]   ram_addr,
    // Program counter and table results
    output logic      [PC_W-1:0]     pc,
    output logic                     busy,
    output logic                     acc_we,
    output logic      [NIB_W-1:0]    acc_out,
    output logic      [NIB_W-1:0]    b_out,
    output logic      [NIB_W-1:0]    port_zero_output,
    output logic      [NIB_W-1:0]    port_one_output
);
    logic [PC_W-1:0]  pc_reg;
    logic [PC_W-1:0]  pc_next;
    logic [PC_W-1:0]  pc_inc;
    logic [PC_W-1:0]  tbl_addr;
    logic [PC_W-1:0]  tbl_addr_reg;
    tbl_state_t       state_reg;
    tbl_state_t       state_next;
    logic             acc_we_reg;
    logic [NIB_W-1:0] acc_reg;
    logic [NIB_W-1:0] b_reg;
    logic [NIB_W-1:0] p0_reg;
    logic [NIB_W-1:0] p1_reg;
    logic             tbl_done;
    logic             to_acc;
    logic             to_port;
    logic [NIB_W-1:0] tbl_hi;
    logic [NIB_W-1:0] tbl_lo;

    // increment carries from the word bits into the page bits.
    assign pc_inc = pc_reg + 14'h0001;
    // immediate selects the page, A and B the low byte.
    // same address for branch and reference.
    assign tbl_addr = {2'b00, imm_nib, acc_in, b_in};
    assign tbl_done = (state_reg == ST_FETCH);
    // the whole ten-bit word is fetched; bits 9 and 8 steer it.
    assign to_acc  = tbl_done & rom_data[SEL_ACC_BIT];
    assign to_port = tbl_done & rom_data[SEL_PORT_BIT];
    // The data byte of a table word, split into its two digits.
    assign tbl_hi  = rom_data[2*NIB_W-1:NIB_W];
    assign tbl_lo  = rom_data[NIB_W-1:0];
    // The ROM is shared: while a table word is read, the PC is not fetched.
    assign rom_addr = tbl_done ? tbl_addr_reg : pc_reg;

    always_comb begin
        pc_next = pc_reg;
        case (branch_op)
            OP_LONG:      pc_next = imm_long;
            // page bits kept. the kept page is the incremented one.
            OP_PAGE_BR:   pc_next = {pc_inc[PC_W-1:PAGE_LSB],
                                     imm_long[PAGE_LSB-1:0]};
            // six low bits, upper bits cleared.
            OP_ZERO_CALL: pc_next = {8'h00, imm_long[ZP_W-1:0]};
            OP_TBL_BR:    pc_next = tbl_addr;
            OP_TBL_REF:   pc_next = pc_inc;
            OP_NONE:      pc_next = pc_inc;
            default:      pc_next = pc_inc;
        endcase
    end

    always_comb begin
        case (state_reg)
            ST_RUN:   state_next = (step && branch_op == OP_TBL_REF)
                                   ? ST_FETCH : ST_RUN;
            ST_FETCH: state_next = ST_RUN;
            default:  state_next = ST_RUN;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pc_reg       <= PC_RESET;
            state_reg    <= ST_RUN;
            tbl_addr_reg <= PC_RESET;
        end else begin
            state_reg <= state_next;
            if (step && !tbl_done) begin
                pc_reg       <= pc_next;
                tbl_addr_reg <= tbl_addr;
            end
        end
    end

    // both destinations may load in the same cycle.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            acc_we_reg <= 1'b0;
            acc_reg    <= NIB_ZERO;
            b_reg      <= NIB_ZERO;
            p0_reg     <= NIB_ZERO;
            p1_reg     <= NIB_ZERO;
        end else begin
            acc_we_reg <= to_acc;
            if (to_acc) begin
                acc_reg <= tbl_hi;
                b_reg   <= tbl_lo;
            end
            if (to_port) begin
                p0_reg <= tbl_lo;
                p1_reg <= tbl_hi;
            end
        end
    end

    ram_addr_mux u_ram_addr_mux (
        .mode        (data_mode),
        .ptr_w       (ptr_w),
        .ptr_x       (ptr_x),
        .ptr_y       (ptr_y),
        .second_word (second_word),
        .memreg_idx  (memreg_idx),
        .ram_addr    (ram_addr)
    );

    assign pc               = pc_reg;
    assign busy             = tbl_done;
    assign acc_we           = acc_we_reg;
    assign acc_out          = acc_reg;
    assign b_out            = b_reg;
    assign port_zero_output = p0_reg;
    assign port_one_output  = p1_reg;

    // low byte from immediate, page kept.
    property p_page_br;
        @(posedge ref_clk) disable iff (srst)
        (step && !tbl_done && branch_op == OP_PAGE_BR && pc_reg[7:0] != 8'hff)
        |=> pc_reg[13:8] == $past(pc_reg[13:8])
            && pc_reg[7:0] == $past(imm_long[7:0]);
    endproperty
    a_page_br: assert property (p_page_br)
        else $error("page branch target wrong");

    // boundary branch lands in next page.
    property p_page_edge;
        @(posedge ref_clk) disable iff (srst)
        (step && !tbl_done && branch_op == OP_PAGE_BR && pc_reg[7:0] == 8'hff)
        |=> pc_reg[13:8] == $past(pc_reg[13:8]) + 6'h01;
    endproperty
    a_page_edge: assert property (p_page_edge)
        else $error("boundary page branch stayed in page");

    property p_long;
        @(posedge ref_clk) disable iff (srst)
        (step && !tbl_done && branch_op == OP_LONG) |=> pc_reg == $past(imm_long);
    endproperty
    a_long: assert property (p_long)
        else $error("long branch target wrong");

    property p_zero;
        @(posedge ref_clk) disable iff (srst)
        (step && !tbl_done && branch_op == OP_ZERO_CALL)
        |=> pc_reg[13:6] == 8'h00 && pc_reg[5:0] == $past(imm_long[5:0]);
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero page call target wrong");

    property p_tbr;
        @(posedge ref_clk) disable iff (srst)
        (step && !tbl_done && branch_op == OP_TBL_BR)
        |=> pc_reg == {2'b00, $past(imm_nib), $past(acc_in), $past(b_in)};
    endproperty
    a_tbr: assert property (p_tbr)
        else $error("table branch target wrong");

    // reference steps PC by one and then reads the table address.
    property p_ref_pc;
        @(posedge ref_clk) disable iff (srst)
        (step && !tbl_done && branch_op == OP_TBL_REF)
        |=> pc_reg == $past(pc_reg) + 14'h0001 ##0 busy ##1 !busy;
    endproperty
    a_ref_pc: assert property (p_ref_pc)
        else $error("table reference disturbed the program counter");

    property p_ref_addr;
        @(posedge ref_clk) disable iff (srst)
        (step && !tbl_done && branch_op == OP_TBL_REF)
        |=> rom_addr == {2'b00, $past(imm_nib), $past(acc_in), $past(b_in)};
    endproperty
    a_ref_addr: assert property (p_ref_addr)
        else $error("table reference address wrong");

    property p_acc;
        @(posedge ref_clk) disable iff (srst)
        (busy && rom_data[SEL_ACC_BIT])
        |=> acc_we && {acc_out, b_out} == $past({tbl_hi, tbl_lo});
    endproperty
    a_acc: assert property (p_acc)
        else $error("accumulator pair not loaded");

    // bit 9 loads ports, otherwise they hold.
    property p_port;
        @(posedge ref_clk) disable iff (srst)
        busy |=> (($past(rom_data[SEL_PORT_BIT]) &&
                   {port_one_output, port_zero_output}
                   == $past({tbl_hi, tbl_lo}))
                  || (!$past(rom_data[SEL_PORT_BIT]) &&
                      $stable({port_one_output, port_zero_output})));
    endproperty
    a_port: assert property (p_port)
        else $error("port output registers handled wrongly");

    // clear bit 8 leaves the pair alone.
    property p_acc_hold;
        @(posedge ref_clk) disable iff (srst)
        (busy && !rom_data[SEL_ACC_BIT])
        |=> !acc_we && $stable({acc_out, b_out});
    endproperty
    a_acc_hold: assert property (p_acc_hold)
        else $error("accumulator pair changed without bit 8");

    // a step during the table read is ignored.
    property p_busy_pc;
        @(posedge ref_clk) disable iff (srst)
        busy |=> $stable(pc);
    endproperty
    a_busy_pc: assert property (p_busy_pc)
        else $error("program counter moved during table read");
endmodule // address_generation_unit

// >>> testbench/rom_model.sv
// Asynchronous program ROM model whose words follow a fixed address pattern.
`timescale 1ns/1ps
module rom_model import agu_pkg::*; (
    // Address and word
    input  wire logic [PC_W-1:0]   addr,
    output logic      [WORD_W-1:0] data
);
    // ten-bit word
    // The flag bits follow the address so each flag mix is reachable.
    assign data = {addr[1:0], addr[7:0] ^ {addr[11:8], addr[11:8]}};
endmodule // rom_model

// >>> testbench/address_generation_unit_tb_top.sv
// Self-checking testbench of the address generation unit.
`timescale 1ns/1ps
module address_generation_unit_tb_top import agu_pkg::*;;
    logic ref_clk = 1'b0, srst = 1'b1, step = 1'b0;
    branch_op_t op_r = OP_NONE;
    logic [PC_W-1:0]   imm_long = '0, exp_pc = '0, rom_addr, pc;
    logic [NIB_W-1:0]  imm_nib = '0, acc_in = '0, b_in = '0, memreg_idx = '0;
    logic [NIB_W-1:0]  ptr_w = '0, ptr_x = '0, ptr_y = '0;
    logic [NIB_W-1:0]  acc_out, b_out, pz, po, ea, eb, ez, eo;
    logic [WORD_W-1:0] rom_data, second_word = '0;
    logic [RAM_AW-1:0] ram_addr;
    logic busy, acc_we;
    data_mode_t dmode = DM_INDIRECT;
    int err_total = 0, checked = 0;
    address_generation_unit DUT (.ref_clk(ref_clk), .srst(srst),
        .step(step), .branch_op(op_r), .imm_long(imm_long),
        .imm_nib(imm_nib), .acc_in(acc_in), .b_in(b_in),
        .rom_addr(rom_addr), .rom_data(rom_data), .data_mode(dmode),
        .ptr_w(ptr_w), .ptr_x(ptr_x), .ptr_y(ptr_y),
        .second_word(second_word), .memreg_idx(memreg_idx),
        .ram_addr(ram_addr), .pc(pc), .busy(busy), .acc_we(acc_we),
        .acc_out(acc_out), .b_out(b_out), .port_zero_output(pz),
        .port_one_output(po));
    rom_model rom (.addr(rom_addr), .data(rom_data));
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // One instruction: request at one edge, taken at the next.
    task automatic issue(input branch_op_t op, input logic [13:0] imm,
                         input logic [3:0] n, a, b);
        @(posedge ref_clk);
        step <= 1'b1; op_r <= op; imm_long <= imm;
        imm_nib <= n; acc_in <= a; b_in <= b;
        @(posedge ref_clk);
        step <= 1'b0; op_r <= OP_NONE;
        #1;
    endtask
    task automatic test_branches();
        issue(OP_LONG, 14'h3fff, 4'h0, 4'h0, 4'h0);
        chk(pc, 14'h3fff);
        issue(OP_LONG, 14'h12ff, 4'h0, 4'h0, 4'h0);
        chk(pc, 14'h12ff);
        // Last word of a page: target lands in the following page.
        issue(OP_PAGE_BR, 14'h2a34, 4'h0, 4'h0, 4'h0);
        chk(pc, 14'h1334);
        issue(OP_PAGE_BR, 14'h3f00, 4'h0, 4'h0, 4'h0);
        chk(pc, 14'h1300);
        issue(OP_ZERO_CALL, 14'h3fea, 4'h0, 4'h0, 4'h0);
        chk(pc, 14'h002a);
        // A plain step from the last word of a page carries into the page.
        issue(OP_LONG, 14'h00ff, 4'h0, 4'h0, 4'h0);
        issue(OP_NONE, 14'h0000, 4'h0, 4'h0, 4'h0);
        chk(pc, 14'h0100);
        issue(OP_TBL_BR, 14'h3fff, 4'h5, 4'ha, 4'h3);
        chk(pc, 14'h05a3);
        exp_pc = 14'h05a3;
        $display("branch test done");
    endtask
    task automatic test_table_ref();
        logic [7:0] byt;
        logic [1:0] fl;
        ea = '0; eb = '0; ez = '0; eo = '0;
        for (int i = 0; i < 4; i++) begin
            fl = 2'(i);
            byt = {4'h6, 2'b11, fl} ^ 8'h99;
            issue(OP_TBL_REF, 14'h0000, 4'h9, 4'h6, {2'b11, fl});
            exp_pc = exp_pc + 14'h0001;
            chk_bit(busy, 1'b1);
            chk(rom_addr, {2'b00, 4'h9, 4'h6, 2'b11, fl});
            for (int k = 0; k < 4 && busy !== 1'b0; k++) begin
                @(posedge ref_clk);
                #1;
            end
            if (busy !== 1'b0) begin
                err_total++;
                complete_run();
            end
            if (fl[0]) begin
                ea = byt[7:4];
                eb = byt[3:0];
            end
            if (fl[1]) begin
                eo = byt[7:4];
                ez = byt[3:0];
            end
            chk_bit(acc_we, fl[0]);
            chk({acc_out, b_out}, {ea, eb});
            chk({po, pz}, {eo, ez});
            chk(pc, exp_pc);
        end
        $display("table reference test done");
    endtask
    // A step held into the table read cycle must be ignored.
    task automatic test_refused();
        @(posedge ref_clk);
        step <= 1'b1;
        op_r <= OP_TBL_REF;
        imm_nib <= 4'h9;
        acc_in <= 4'h6;
        b_in <= 4'hc;
        @(posedge ref_clk);
        op_r <= OP_LONG;
        imm_long <= 14'h2222;
        @(posedge ref_clk);
        step <= 1'b0;
        op_r <= OP_NONE;
        #1;
        exp_pc = exp_pc + 14'h0001;
        chk_bit(busy, 1'b0);
        chk(pc, exp_pc);
        chk_bit(acc_we, 1'b0);
        $display("refused step test done");
    endtask
    // Reset during a table read drops it; the next step works at once.
    task automatic test_mid_reset();
        @(posedge ref_clk);
        step <= 1'b1;
        op_r <= OP_TBL_REF;
        b_in <= 4'hf;
        @(posedge ref_clk);
        step <= 1'b0;
        op_r <= OP_NONE;
        srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        #1;
        chk(pc, PC_RESET);
        chk_bit(busy, 1'b0);
        chk_bit(acc_we, 1'b0);
        chk({acc_out, b_out, po, pz}, 16'h0000);
        issue(OP_LONG, 14'h0abc, 4'h0, 4'h0, 4'h0);
        chk(pc, 14'h0abc);
        $display("mid-run reset test done");
    endtask
    task automatic test_ram_modes();
        @(posedge ref_clk);
        dmode <= DM_INDIRECT; ptr_w <= 4'h2; ptr_x <= 4'hb; ptr_y <= 4'h7;
        #1;
        chk(ram_addr, 10'h2b7);
        @(posedge ref_clk);
        dmode <= DM_DIRECT; second_word <= 10'h3c5;
        #1;
        chk(ram_addr, 10'h3c5);
        for (int i = 0; i < 16; i += 15) begin
            @(posedge ref_clk);
            dmode <= DM_MEMREG; memreg_idx <= 4'(i);
            #1;
            chk(ram_addr, 10'h040 + 10'(i));
        end
        $display("ram addressing test done");
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        #1;
        chk(pc, 14'h0000);
        test_branches();
        test_table_ref();
        test_refused();
        test_mid_reset();
        test_ram_modes();
        complete_run();
    end
endmodule // address_generation_unit_tb_top
